/* design/tqt_trigger.sv */
// time qualified trigger: pattern of three threshold states arms a
// qualifier that gates edges of a selected trigger source.
// assumes threshold and source inputs are synchronous to clk and that
// software uses a plain one-cycle strobe register port.
// every output leaves a flip-flop; the block raises no interrupt.
// a source select of 3 behaves as the first input everywhere.
`include "tqt_params.svh"

module tqt_trigger
  import tqt_pkg::*;
#(
  parameter int TW = 32,
  parameter int CW = 24
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        first_input_above,
  input  wire logic        second_input_above,
  input  wire logic        external_input_above,
  output logic             trig_out,
  output logic             armed_out
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // one pattern term; X or a forced source term always matches
  function automatic logic term_match(input logic [1:0] code, input logic lvl);
    case (code)
      TQT_T_H: term_match = lvl;
      TQT_T_L: term_match = !lvl;
      default: term_match = 1'b1;
    endcase
  endfunction : term_match

  // source decode; code 3 falls back to the first input
  function automatic logic is_source(input logic [1:0] sel, input logic [1:0] idx);
    if (sel == 2'h3)
      is_source = idx == 2'h0;
    else
      is_source = sel == idx;
  endfunction : is_source

  //////////////////////////////////////////////////////////////////////
  // registers
  // narrow fields sit in the low bits and read back as zero above

  logic [31:0] ctrl_r;
  logic [5:0]  pattern_r;
  logic [TW-1:0] time_a_r;
  logic [TW-1:0] time_b_r;
  logic [CW-1:0] count_r;
  logic [15:0] trig_cnt_r;
  logic [31:0] rd_data_nxt;

  wire sel_ctrl    = addr == `TQT_OFS_CTRL;
  wire sel_pattern = addr == `TQT_OFS_PATTERN;
  wire sel_time_a  = addr == `TQT_OFS_TIME_A;
  wire sel_time_b  = addr == `TQT_OFS_TIME_B;
  wire sel_count   = addr == `TQT_OFS_COUNT;
  wire sel_status  = addr == `TQT_OFS_STATUS;

  // control fields
  wire         enable   = ctrl_r[`TQT_CTRL_EN];
  wire         on_exit  = ctrl_r[`TQT_CTRL_EXIT];
  wire         on_rise  = ctrl_r[`TQT_CTRL_RISE];
  wire [1:0]   src_sel  = ctrl_r[`TQT_CTRL_SRC_HI:`TQT_CTRL_SRC_LO];
  wire [2:0]   mode     = ctrl_r[`TQT_CTRL_MODE_HI:`TQT_CTRL_MODE_LO];
  wire         unit_us  = ctrl_r[`TQT_CTRL_UNIT];

  // register writes; one-cycle strobe, no wait state
  // unmapped offsets fall away without any sign to software
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r    <= `TQT_RST_CTRL;
      pattern_r <= 6'(`TQT_RST_PATTERN);
      time_a_r  <= TW'(`TQT_TMIN_CYC);
      time_b_r  <= TW'(`TQT_TMIN_CYC);
      count_r   <= CW'(`TQT_RST_COUNT);
    end
    else if (wr_en)
    begin
      if (sel_ctrl)    ctrl_r    <= {23'h0, wr_data[8:0]};
      if (sel_pattern) pattern_r <= wr_data[5:0];
      if (sel_time_a)  time_a_r  <= wr_data[TW-1:0];
      if (sel_time_b)  time_b_r  <= wr_data[TW-1:0];
      if (sel_count)   count_r   <= wr_data[CW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // input sampling and pattern

  logic first_r;
  logic second_r;
  logic ext_r;
  logic src_d_r;
  logic pat_d_r;

  // sample the comparator states once so every term sees the same cycle
  // costs one cycle of latency but keeps the terms and the source aligned
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_r  <= 1'b0;
      second_r <= 1'b0;
      ext_r    <= 1'b0;
    end
    else
    begin
      first_r  <= first_input_above;
      second_r <= second_input_above;
      ext_r    <= external_input_above;
    end
  end

  // source term is forced to don't care
  // a source that also sat in the pattern could qualify itself
  wire [1:0] first_input_term    = is_source(src_sel, 2'h0) ? 2'h0
                                   : pattern_r[`TQT_PAT_FIRST +: 2];
  wire [1:0] second_input_term   = is_source(src_sel, 2'h1) ? 2'h0
                                   : pattern_r[`TQT_PAT_SECOND +: 2];
  wire [1:0] external_input_term = is_source(src_sel, 2'h2) ? 2'h0
                                   : pattern_r[`TQT_PAT_EXT +: 2];

  // and of the three terms
  // an all-ignored pattern is always true, so it enters once after reset or when set, then never transitions
  wire m_first  = term_match(first_input_term, first_r);
  wire m_second = term_match(second_input_term, second_r);
  wire m_ext    = term_match(external_input_term, ext_r);
  wire pattern_true = m_first & m_second & m_ext;

  // entering or exiting transition arms the qualifier
  // the previous level is tracked even while disabled, so enabling with
  // the pattern already true does not arm by itself
  wire enter_evt = pattern_true & !pat_d_r;
  wire exit_evt  = !pattern_true & pat_d_r;
  wire arm_evt   = enable & (on_exit ? exit_evt : enter_evt);

  // trigger source and its edge
  // the level mux and the pattern forcing share one source decode, so the
  // input that triggers is always the one left out of the pattern
  wire src_lvl = is_source(src_sel, 2'h1) ? second_r
               : is_source(src_sel, 2'h2) ? ext_r : first_r;
  wire src_edge = on_rise ? (src_lvl & !src_d_r)
                          : (!src_lvl & src_d_r);

  // previous levels for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat_d_r <= 1'b0;
      src_d_r <= 1'b0;
    end
    else
    begin
      pat_d_r <= pattern_true;
      src_d_r <= src_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timebase and elapsed time
  // in the 10 ns unit every cycle is one tick; the microsecond unit
  // trades resolution for range through a divide-by-100 enable

  logic [6:0]    div_r;
  logic [TW-1:0] elapsed;

  // microsecond unit keeps 100 s within a 32-bit count
  wire div_wrap = div_r == 7'(`TQT_USEC_CYC - 1);
  wire tick     = unit_us ? div_wrap : 1'b1;

  // divider restarts with the timer so a window is not short by a fraction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_r <= 7'h00;
    else if (arm_evt || div_wrap)
      div_r <= 7'h00;
    else
      div_r <= div_r + 7'h01;
  end

  // elapsed ticks since the last selected transition, saturating
  // so a very late edge still counts as late
  tqt_timer #(
    .W      (TW)
  ) u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .clear  (arm_evt),
    .tick   (tick),
    .count  (elapsed)
  );

  //////////////////////////////////////////////////////////////////////
  // qualifier
  // armed from a selected transition until a trigger fires or enable drops;
  // a transition while armed restarts time and count instead of firing,
  // so a source edge in that same cycle is dropped on purpose

  tqt_state_type state_r;
  tqt_state_type state_nxt;
  logic [CW-1:0] events_r;
  logic [CW-1:0] events_nxt;
  logic          fire;

  wire in_range   = (elapsed >= time_a_r) && (elapsed <= time_b_r);
  wire events_hit = (events_r + 1'b1) == count_r;

  // qualification per mode; edge in the arming cycle is not counted
  always_comb
  begin
    fire = 1'b0;
    if (state_r == TQT_S_ARMED && src_edge && !arm_evt)
    begin
      case (mode)
        TQT_Q_WAIT:    fire = elapsed >= time_a_r;
        TQT_Q_BEFORE:  fire = elapsed < time_a_r;
        TQT_Q_BETWEEN: fire = in_range;
        TQT_Q_OUTSIDE: fire = !in_range;
        TQT_Q_EVENTS:  fire = events_hit;
        default:       fire = 1'b0;
      endcase
    end
  end

  // event counter runs from one transition to the next
  // it wraps at CW bits; a count written beyond that range keeps only its low CW bits
  // a count of zero matches only on the edge that wraps the counter, which leaves the qualifier armed until then
  assign events_nxt = arm_evt ? '0
                    : (state_r == TQT_S_ARMED && src_edge) ? events_r + 1'b1
                    : events_r;

  // armed until a trigger fires or the block is disabled
  // an unknown code falls back to idle rather than locking up
  always_comb
  begin
    case (state_r)
      TQT_S_IDLE:  state_nxt = arm_evt ? TQT_S_ARMED : TQT_S_IDLE;
      TQT_S_ARMED: state_nxt = (!enable || (fire && !arm_evt)) ? TQT_S_IDLE
                               : TQT_S_ARMED;
      default:     state_nxt = TQT_S_IDLE;
    endcase
  end

  // state, counter and outputs
  // outputs are registered copies so they stay glitch free at the pins
  // the trigger count wraps at 16 bits; software reads it as a delta
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r    <= TQT_S_IDLE;
      events_r   <= '0;
      trig_out   <= 1'b0;
      armed_out  <= 1'b0;
      trig_cnt_r <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      events_r   <= events_nxt;
      trig_out   <= fire;
      armed_out  <= state_nxt == TQT_S_ARMED;
      trig_cnt_r <= trig_cnt_r + {15'h0000, fire};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe
  // status: [0] source level, [1] state armed, [2] armed output,
  // [3] pattern true, [31:16] trigger count

  assign rd_data_nxt =
      sel_ctrl    ? ctrl_r
    : sel_pattern ? {26'h0, pattern_r}
    : sel_time_a  ? 32'(time_a_r)
    : sel_time_b  ? 32'(time_b_r)
    : sel_count   ? 32'(count_r)
    : sel_status  ? {trig_cnt_r, 12'h000, pattern_true, armed_out,
                     state_r == TQT_S_ARMED, src_lvl}
    : 32'h0000_0000;

  // read data holds only in the cycle after the strobe
  // idle cycles show zero so a stale word is never taken for a fresh one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= 32'h0000_0000;
    else
      rd_data <= rd_en ? rd_data_nxt : 32'h0000_0000;
  end

endmodule : tqt_trigger

/* design/tqt_params.svh */
// constants for the time qualified trigger: offsets, field positions,
// reset values and timing counts; assumes a 100 MHz system clock.
`ifndef TQT_PARAMS_SVH
`define TQT_PARAMS_SVH

// register byte offsets
`define TQT_OFS_CTRL     8'h00
`define TQT_OFS_PATTERN  8'h04
`define TQT_OFS_TIME_A   8'h08
`define TQT_OFS_TIME_B   8'h0C
`define TQT_OFS_COUNT    8'h10
`define TQT_OFS_STATUS   8'h14

// control fields
`define TQT_CTRL_EN      0
`define TQT_CTRL_EXIT    1
`define TQT_CTRL_RISE    2
`define TQT_CTRL_SRC_LO  3
`define TQT_CTRL_SRC_HI  4
`define TQT_CTRL_MODE_LO 5
`define TQT_CTRL_MODE_HI 7
`define TQT_CTRL_UNIT    8

// pattern fields, two bits per term
`define TQT_PAT_FIRST    0
`define TQT_PAT_SECOND   2
`define TQT_PAT_EXT      4

// timing
`define TQT_CLK_NS       10
`define TQT_TMIN_NS      10
`define TQT_TMIN_CYC     ((`TQT_TMIN_NS + `TQT_CLK_NS - 1) / `TQT_CLK_NS)
`define TQT_USEC_NS      1000
`define TQT_USEC_CYC     (`TQT_USEC_NS / `TQT_CLK_NS)
`define TQT_WMIN_US      10

// reset values
`define TQT_RST_CTRL     32'h0000_0004
`define TQT_RST_PATTERN  32'h0000_0000
`define TQT_RST_COUNT    32'h0000_0001

`endif

/* design/tqt_pkg.sv */
// types shared by the time qualified trigger files.
// assumes nothing beyond a SystemVerilog compiler.
package tqt_pkg;

  // qualifier selection codes
  typedef enum logic [2:0] {
    TQT_Q_WAIT    = 3'h0,
    TQT_Q_BEFORE  = 3'h1,
    TQT_Q_BETWEEN = 3'h2,
    TQT_Q_OUTSIDE = 3'h3,
    TQT_Q_EVENTS  = 3'h4
  } tqt_mode_type;

  // pattern term codes
  typedef enum logic [1:0] {
    TQT_T_X = 2'h0,
    TQT_T_H = 2'h1,
    TQT_T_L = 2'h2
  } tqt_term_type;

  // qualifier state, one-hot
  typedef enum logic [1:0] {
    TQT_S_IDLE  = 2'b01,
    TQT_S_ARMED = 2'b10
  } tqt_state_type;

endpackage : tqt_pkg

/* design/tqt_timer.sv */
// saturating elapsed-time counter for the trigger qualifier.
// assumes clear and tick are synchronous one-cycle pulses.
module tqt_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clear,
  input  wire logic         tick,
  output logic [W-1:0]      count
);

  logic [W-1:0] count_nxt;
  wire          at_max = &count;

  // saturate so a long wait never wraps into a false short one
  assign count_nxt = clear ? '0 : ((tick && !at_max) ? count + 1'b1 : count);

  // counter register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= '0;
    else
      count <= count_nxt;
  end

endmodule : tqt_timer

/* tb/tqt_comp_model.sv */
// partner model: threshold comparators ahead of the trigger inputs.
// assumes the bench drives levels right after rising clock edges.
module tqt_comp_model #(
  parameter logic [7:0] THR = 8'h80
) (
  input  wire logic [7:0] lvl_first,
  input  wire logic [7:0] lvl_second,
  input  wire logic [7:0] lvl_ext,
  output logic            first_above,
  output logic            second_above,
  output logic            ext_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // strict compare: a level sitting on threshold reads as low
  assign first_above  = lvl_first > THR;
  assign second_above = lvl_second > THR;
  assign ext_above    = lvl_ext > THR;
endmodule : tqt_comp_model

/* tb/tqt_trigger_chk.sv */
// assertions on the ports of the time qualified trigger.
// assumes it is bound to tqt_trigger with every port connected.
`include "tqt_params.svh"
module tqt_trigger_chk
  import tqt_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  input wire logic        first_input_above,
  input wire logic        second_input_above,
  input wire logic        external_input_above,
  input wire logic        trig_out,
  input wire logic        armed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [8:0] ctrl_r;
  logic [5:0] pat_r;
  logic [2:0] in_r;
  logic       patd_r;
  logic       srcd_r;
  function automatic logic ok(input logic [1:0] c, input logic b);
    return (c == TQT_T_H) ? b : ((c == TQT_T_L) ? !b : 1'b1);
  endfunction : ok
  // source term forced to don't care so it cannot arm itself; code 3 is first
  wire [1:0] src   = ctrl_r[4:3];
  wire       srcq  = (src == 2'h1) ? in_r[1] : ((src == 2'h2) ? in_r[2] : in_r[0]);
  wire       pat   = ok((src == 2'h1 || src == 2'h2) ? pat_r[1:0] : 2'h0, in_r[0])
                   & ok((src == 2'h1) ? 2'h0 : pat_r[3:2], in_r[1])
                   & ok((src == 2'h2) ? 2'h0 : pat_r[5:4], in_r[2]);
  ////////////////////////////////////////
  // shadow of control words and sampled inputs
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      ctrl_r <= 9'h004;
      pat_r  <= 6'h00;
      in_r   <= 3'h0;
      patd_r <= 1'b0;
      srcd_r <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == `TQT_OFS_CTRL) ctrl_r <= wr_data[8:0];
      if (wr_en && addr == `TQT_OFS_PATTERN) pat_r <= wr_data[5:0];
      in_r   <= {external_input_above, second_input_above, first_input_above};
      patd_r <= pat;
      srcd_r <= srcq;
    end
  wire       arm   = ctrl_r[0] & (ctrl_r[1] ? (patd_r & !pat) : (pat & !patd_r));
  wire       sedge = ctrl_r[2] ? (srcq & !srcd_r) : (!srcq & srcd_r);
  ////////////////////////////////////////
  sequence s_fire;
    trig_out ##1 !trig_out;
  endsequence
  sequence s_arm;
    arm ##1 armed_out;
  endsequence
  property p_trig_pulse; trig_out |-> s_fire; endproperty
  property p_trig_armed; trig_out |-> $past(armed_out); endproperty
  property p_trig_edge; trig_out |-> $past(sedge); endproperty
  property p_trig_disarm; trig_out |-> !armed_out; endproperty
  property p_arm; arm |-> s_arm; endproperty
  property p_no_arm; !armed_out && !arm |=> !armed_out; endproperty
  property p_disabled; !ctrl_r[0] [*2] |-> !armed_out; endproperty
  property p_rd_idle; !rd_en |=> rd_data == 32'h0; endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("trigger longer than one cycle");
  a_trig_armed: assert property (p_trig_armed)
    else $error("trigger without armed qualifier");
  a_trig_edge: assert property (p_trig_edge)
    else $error("trigger without matching source edge");
  a_trig_disarm: assert property (p_trig_disarm)
    else $error("still armed after trigger");
  a_arm: assert property (p_arm)
    else $error("transition did not arm");
  a_no_arm: assert property (p_no_arm)
    else $error("armed without transition");
  a_disabled: assert property (p_disabled)
    else $error("armed while disabled");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule : tqt_trigger_chk

/* tb/testbench.sv */
// top bench: register tasks, comparator model and trigger scenarios.
// assumes the checker binds onto tqt_trigger.
`include "tqt_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic [2:0]  hi;
  logic [31:0] trig_cnt;
  wire logic   a0, a1, a2, trig_out, armed_out;
  int          mismatches;
  int          n_checks;
  ////////////////////////////////////////
  tqt_comp_model tqt_comp_model_i (.lvl_first(hi[0] ? 8'hC0 : 8'h40),
    .lvl_second(hi[1] ? 8'hC0 : 8'h40), .lvl_ext(hi[2] ? 8'hC0 : 8'h40),
    .first_above(a0), .second_above(a1), .ext_above(a2));
  tqt_trigger tqt_trigger_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .first_input_above(a0),
    .second_input_above(a1), .external_input_above(a2), .trig_out(trig_out),
    .armed_out(armed_out));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // trigger pulses counted so checks need not hit the exact cycle
  always @(posedge clk)
    if (!arst_n) trig_cnt <= 32'h0;
    else if (trig_out === 1'b1) trig_cnt <= trig_cnt + 32'h1;
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask : rd
  task automatic setp(input logic [2:0] v, input int n);
    hi <= v;
    cyc(n);
  endtask : setp
  // one source pulse, then the count of triggers it caused
  task automatic pulse(input int i, input logic [31:0] e);
    logic [31:0] n;
    n = trig_cnt;
    hi[i] <= 1'b1;
    cyc(3);
    hi[i] <= 1'b0;
    cyc(4);
    chk(trig_cnt - n, e);
  endtask : pulse
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial
  begin
    {hi, addr, wr_data, wr_en, rd_en} = '0;
    arst_n = 1'b0;
    cyc(12);
    arst_n <= 1'b1;
    rd(`TQT_OFS_CTRL, `TQT_RST_CTRL);
    rd(`TQT_OFS_PATTERN, 32'h0);
    rd(`TQT_OFS_TIME_A, 32'h1);
    rd(`TQT_OFS_COUNT, `TQT_RST_COUNT);
    rd(8'h18, 32'h0);
    // wait mode; source H code must be ignored
    wr(`TQT_OFS_PATTERN, 32'h05);
    wr(`TQT_OFS_TIME_A, 32'h14);
    wr(`TQT_OFS_CTRL, 32'h05);
    setp(3'b010, 3);
    chk(32'(armed_out), 32'h1);
    // long enough that a timer left running would already allow a trigger
    cyc(15);
    setp(3'b000, 2);
    setp(3'b010, 3);
    pulse(0, 32'h0);
    setp(3'b000, 20);
    pulse(0, 32'h1);
    pulse(0, 32'h0);
    // and-before window
    wr(`TQT_OFS_CTRL, 32'h25);
    setp(3'b010, 3);
    pulse(0, 32'h1);
    setp(3'b000, 2);
    setp(3'b010, 30);
    pulse(0, 32'h0);
    setp(3'b000, 2);
    setp(3'b010, 14);
    setp(3'b000, 2);
    setp(3'b010, 8);
    pulse(0, 32'h1);
    // width between then outside, range 10..30 ticks
    wr(`TQT_OFS_TIME_A, 32'h0A);
    wr(`TQT_OFS_TIME_B, 32'h1E);
    for (int m = 2; m < 4; m++)
    begin
      wr(`TQT_OFS_CTRL, 32'({m[2:0], 5'h05}));
      setp(3'b000, 2);
      setp(3'b010, 15);
      pulse(0, 32'(m == 2));
      setp(3'b000, 2);
      setp(3'b010, 3);
      pulse(0, 32'(m == 3));
    end
    // third event fires; a new transition restarts the count
    wr(`TQT_OFS_COUNT, 32'h3);
    wr(`TQT_OFS_CTRL, 32'h85);
    for (int k = 0; k < 5; k++)
    begin
      if (k != 2) setp(3'b000, 2);
      if (k != 2) setp(3'b010, 3);
      pulse(0, 32'(k == 2));
      pulse(0, 32'h0);
    end
    rd(`TQT_OFS_COUNT, 32'h3);
    // exiting, falling edge, second input as source, microsecond unit
    wr(`TQT_OFS_PATTERN, 32'h29);
    wr(`TQT_OFS_TIME_A, 32'h2);
    wr(`TQT_OFS_CTRL, 32'h10B);
    setp(3'b001, 3);
    setp(3'b101, 3);
    pulse(1, 32'h0);
    cyc(200);
    pulse(1, 32'h1);
    setp(3'b001, 3);
    setp(3'b101, 3);
    wr(`TQT_OFS_CTRL, 32'h0);
    cyc(2);
    chk(32'(armed_out), 32'h0);
    // eight triggers so far, source level high, pattern false, idle
    rd(`TQT_OFS_STATUS, 32'h0008_0001);
    report_and_stop();
  end
endmodule : testbench

bind tqt_trigger tqt_trigger_chk tqt_trigger_chk_i (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .first_input_above(first_input_above), .second_input_above(second_input_above),
  .external_input_above(external_input_above), .trig_out(trig_out), .armed_out(armed_out));
